// ### logic/asc_defs.svh
// timing figures and pin encodings for the static ram controller
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

`define ASC_CLK_PERIOD_NS 4
// least time in ns to whole clock cycles, rounding up
`define ASC_CYC_UP(t) (((t) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)

`define ASC_READ_PERIOD_MIN_NS 45
`define ASC_ADDR_ACCESS_MAX_NS 45
`define ASC_ADDR_CHANGE_HOLD_MIN_NS 10
`define ASC_SELECT_ACCESS_MAX_NS 45
`define ASC_GATE_ACCESS_MAX_NS 22
`define ASC_LANE_ACCESS_MAX_NS 45
`define ASC_GATE_RELEASE_MAX_NS 18
`define ASC_WRITE_PERIOD_MIN_NS 45
`define ASC_SELECT_TO_WRITE_END_MIN_NS 35
`define ASC_ADDR_SETUP_WRITE_END_MIN_NS 35
`define ASC_ADDR_HOLD_AFTER_WRITE_MIN_NS 0
`define ASC_STROBE_WIDTH_MIN_NS 35
`define ASC_LANE_TO_WRITE_END_MIN_NS 35
`define ASC_WDATA_SETUP_MIN_NS 25
`define ASC_WDATA_HOLD_MIN_NS 0
`define ASC_STROBE_RELEASE_MAX_NS 18
`define ASC_STROBE_REDRIVE_MIN_NS 10

// cycles the read strobes stay on before data is sampled
`define ASC_READ_CYC `ASC_CYC_UP(`ASC_READ_PERIOD_MIN_NS)
// cycles to wait for the memory to float after the gate goes high
`define ASC_GATE_RELEASE_CYC `ASC_CYC_UP(`ASC_GATE_RELEASE_MAX_NS)
// cycles after strobe low before the controller may drive data
`define ASC_STROBE_RELEASE_CYC `ASC_CYC_UP(`ASC_STROBE_RELEASE_MAX_NS)
// cycles write data is driven before the write ends
`define ASC_WDATA_SETUP_CYC `ASC_CYC_UP(`ASC_WDATA_SETUP_MIN_NS)
`define ASC_WRITE_CYC `ASC_CYC_UP(`ASC_WRITE_PERIOD_MIN_NS)

`define ASC_ADDR_W 20
`define ASC_DATA_W 16
`define ASC_CNT_W 5
`define ASC_LANE_OFF 2'b11
`define ASC_DATA_IDLE 16'h0000
`define ASC_ADDR_IDLE 20'h00000
`define ASC_CNT_ZERO 5'h00
`define ASC_CNT_ONE 5'h01

`endif

// ### logic/asc_pkg.sv
// types for the static ram controller
`include "asc_defs.svh"

package asc_pkg;
    typedef logic [`ASC_ADDR_W-1:0] asc_addr_t;
    typedef logic [`ASC_DATA_W-1:0] asc_data_t;
    typedef logic [`ASC_CNT_W-1:0] asc_cnt_t;
    typedef logic [1:0] asc_lane_t;
    typedef enum logic [2:0] {
        ASC_IDLE,
        ASC_RD,
        ASC_RD_REL,
        ASC_WR_WAIT,
        ASC_WR_DATA,
        ASC_WR_HOLD
    } asc_state_e;
endpackage

// ### logic/asc_tmr_if.sv
// carrier between the sequencer and its interval timer
`timescale 1ns/1ps

interface asc_tmr_if;
    import asc_pkg::*;
    logic load;
    asc_cnt_t value;
    logic done;
    modport ctrl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface

// ### logic/asc_timer.sv
// down counter that flags when a loaded interval has run out
`timescale 1ns/1ps
`include "asc_defs.svh"

module asc_timer (
    input wire logic i_clk, // system clock
    input wire logic i_srst, // synchronous reset, active high
    input wire logic i_ce, // clock enable
    asc_tmr_if.tmr tif // load and done
);
    import asc_pkg::*;

    asc_cnt_t cnt_r;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_r <= `ASC_CNT_ZERO;
        end else if (i_ce) begin
            if (tif.load) begin
                cnt_r <= tif.value;
            end else if (cnt_r != `ASC_CNT_ZERO) begin
                cnt_r <= cnt_r - `ASC_CNT_ONE;
            end
        end
    end

    // done must not look at load: the sequencer derives load from done
    assign tif.done = (cnt_r == `ASC_CNT_ZERO);
endmodule // asc_timer

// ### logic/asc_ctrl.sv
// clocked controller for a 1M x 16 asynchronous static ram
// What this block does
// - read cycle lasts at least 45 ns
// - write cycle lasts at least 45 ns
// - selects active 35 ns before write end
// - address stable 35 ns before write end
// - address held until write has ended
// - write strobe low at least 35 ns
// - lane selects active 35 ns before end
// - write data set up 25 ns, zero hold
// - write only while all qualifiers active
// - setup measured from the ending edge
// - strobe width covers setup plus release
// - never drive bus while memory drives
`timescale 1ns/1ps
`include "asc_defs.svh"

module asc_ctrl (
    input wire logic I_CLK, // 250 MHz clock
    input wire logic I_SRST, // synchronous reset, active high
    input wire logic I_CE, // clock enable, freezes state when low
    input wire logic I_REQ, // request strobe, taken when O_READY
    input wire logic I_WRITE, // 1 write, 0 read
    input wire asc_pkg::asc_addr_t I_ADDR, // word address
    input wire asc_pkg::asc_data_t I_WDATA, // write data
    input wire asc_pkg::asc_lane_t I_LANE_N, // lane selects, bit1 upper, active low
    output logic O_READY, // idle, a request may be taken
    output logic O_RVALID, // one-cycle pulse with read data
    output asc_pkg::asc_data_t O_RDATA, // captured read data
    output asc_pkg::asc_addr_t O_ADDR, // memory address pins
    output logic O_SELECT_LOW_ACTIVE_N, // active-low chip select
    output logic O_SELECT_HIGH_ACTIVE, // active-high chip select
    output logic O_WRITE_STROBE_N, // write strobe
    output logic O_OUTPUT_GATE_N, // output gate
    output logic O_UPPER_LANE_SELECT_N, // lane select bits 15..8
    output logic O_LOWER_LANE_SELECT_N, // lane select bits 7..0
    input wire asc_pkg::asc_data_t I_DQ, // data pins, input side
    output asc_pkg::asc_data_t O_DQ, // data pins, output side
    output logic O_DQ_OE // data pins driven while high
);
    import asc_pkg::*;

    localparam asc_cnt_t READ_LOAD = asc_cnt_t'(`ASC_READ_CYC - 1);
    localparam asc_cnt_t GATE_REL_LOAD = asc_cnt_t'(`ASC_GATE_RELEASE_CYC - 1);
    localparam asc_cnt_t STROBE_REL_LOAD = asc_cnt_t'(`ASC_STROBE_RELEASE_CYC - 1);
    localparam asc_cnt_t WDATA_LOAD = asc_cnt_t'(`ASC_WDATA_SETUP_CYC - 1);
    localparam asc_lane_t LANE_OFF = `ASC_LANE_OFF;

    asc_state_e state_r;
    asc_state_e state_nxt;
    logic take;
    logic sel_on;
    asc_tmr_if tif ();

    asc_timer u_timer (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_ce(I_CE),
        .tif(tif)
    );

    assign take = O_READY && I_REQ;
    assign sel_on = (state_r == ASC_IDLE) ? take : (state_nxt != ASC_IDLE);

    // next state and timer loads
    always_comb begin
        state_nxt = state_r;
        tif.load = 1'b0;
        tif.value = `ASC_CNT_ZERO;
        case (state_r)
            ASC_IDLE: begin
                if (take && I_WRITE) begin
                    state_nxt = ASC_WR_WAIT;
                    tif.load = 1'b1;
                    tif.value = STROBE_REL_LOAD;
                end else if (take) begin
                    state_nxt = ASC_RD;
                    tif.load = 1'b1;
                    tif.value = READ_LOAD;
                end
            end
            ASC_RD: begin
                if (tif.done) begin
                    state_nxt = ASC_RD_REL;
                    tif.load = 1'b1;
                    tif.value = GATE_REL_LOAD;
                end
            end
            ASC_RD_REL: begin
                if (tif.done) begin
                    state_nxt = ASC_IDLE;
                end
            end
            ASC_WR_WAIT: begin
                if (tif.done) begin
                    state_nxt = ASC_WR_DATA;
                    tif.load = 1'b1;
                    tif.value = WDATA_LOAD;
                end
            end
            ASC_WR_DATA: begin
                if (tif.done) begin
                    state_nxt = ASC_WR_HOLD;
                end
            end
            ASC_WR_HOLD: begin
                state_nxt = ASC_IDLE;
            end
            default: begin
                state_nxt = ASC_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_r <= ASC_IDLE;
        end else if (I_CE) begin
            state_r <= state_nxt;
        end
    end

    // request port handshake
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_READY <= 1'b1;
        end else if (I_CE) begin
            O_READY <= (state_nxt == ASC_IDLE);
        end
    end

    // read data capture once the slowest access time has passed
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_RVALID <= 1'b0;
            O_RDATA <= `ASC_DATA_IDLE;
        end else if (I_CE) begin
            O_RVALID <= 1'b0;
            if (state_r == ASC_RD && tif.done) begin
                O_RVALID <= 1'b1;
                O_RDATA <= I_DQ;
            end
        end
    end

    // address held for the whole cycle, changed only from idle
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_ADDR <= `ASC_ADDR_IDLE;
        end else if (I_CE && take) begin
            O_ADDR <= I_ADDR;
        end
    end

    // chip selects: active across the whole access, off between
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_SELECT_LOW_ACTIVE_N <= 1'b1;
            O_SELECT_HIGH_ACTIVE <= 1'b0;
        end else if (I_CE) begin
            O_SELECT_LOW_ACTIVE_N <= !(sel_on && state_nxt != ASC_RD_REL
                && state_nxt != ASC_WR_HOLD);
            O_SELECT_HIGH_ACTIVE <= sel_on && state_nxt != ASC_RD_REL
                && state_nxt != ASC_WR_HOLD;
        end
    end

    // lane selects follow the request for its duration
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_UPPER_LANE_SELECT_N <= 1'b1;
            O_LOWER_LANE_SELECT_N <= 1'b1;
        end else if (I_CE) begin
            if (take) begin
                O_UPPER_LANE_SELECT_N <= I_LANE_N[1];
                O_LOWER_LANE_SELECT_N <= I_LANE_N[0];
            end else if (state_nxt == ASC_RD_REL || state_nxt == ASC_WR_HOLD
                || state_nxt == ASC_IDLE) begin
                O_UPPER_LANE_SELECT_N <= LANE_OFF[1];
                O_LOWER_LANE_SELECT_N <= LANE_OFF[0];
            end
        end
    end

    // output gate low only during a read access
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_OUTPUT_GATE_N <= 1'b1;
        end else if (I_CE) begin
            O_OUTPUT_GATE_N <= (state_nxt != ASC_RD);
        end
    end

    // write strobe: low from request until data setup has elapsed
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_WRITE_STROBE_N <= 1'b1;
        end else if (I_CE) begin
            O_WRITE_STROBE_N <= !(state_nxt == ASC_WR_WAIT
                || state_nxt == ASC_WR_DATA);
        end
    end

    // write data latched at the request and driven after the memory floats
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_DQ <= `ASC_DATA_IDLE;
        end else if (I_CE && take && I_WRITE) begin
            O_DQ <= I_WDATA;
        end
    end

    // drive stays one cycle past the strobe rise, well inside re-drive time
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_DQ_OE <= 1'b0;
        end else if (I_CE) begin
            O_DQ_OE <= (state_nxt == ASC_WR_DATA
                || state_nxt == ASC_WR_HOLD);
        end
    end
endmodule // asc_ctrl

// ### test/asc_ctrl_props.sv
// assertion checker for the static ram controller pins
`timescale 1ns/1ps

module asc_ctrl_props (
    input wire logic I_CLK, // clock
    input wire logic I_SRST, // reset
    input wire asc_pkg::asc_addr_t O_ADDR, // address pins
    input wire asc_pkg::asc_data_t O_DQ, // data out
    input wire logic O_DQ_OE, // data enable
    input wire logic O_SELECT_LOW_ACTIVE_N, // select low
    input wire logic O_SELECT_HIGH_ACTIVE, // select high
    input wire logic O_WRITE_STROBE_N, // strobe
    input wire logic O_OUTPUT_GATE_N, // gate
    input wire logic O_UPPER_LANE_SELECT_N, // upper lane
    input wire logic O_LOWER_LANE_SELECT_N // lower lane
);
    import asc_pkg::*;
    logic [4:0] wl_r, sl_r, oe_r, gl_r, ws_r;
    logic sel;
    assign sel = !O_SELECT_LOW_ACTIVE_N && O_SELECT_HIGH_ACTIVE;
    function automatic logic [4:0] inc(input logic [4:0] v);
        return (v == 5'h1f) ? v : v + 5'h01;
    endfunction
    // run lengths of strobe low, selects on, data drive and gate low, and cycles since the strobe fell, saturating
    always_ff @(posedge I_CLK) begin
        wl_r <= (I_SRST || O_WRITE_STROBE_N) ? 5'h00 : inc(wl_r);
        sl_r <= (I_SRST || !sel) ? 5'h00 : inc(sl_r);
        oe_r <= (I_SRST || !O_DQ_OE) ? 5'h00 : inc(oe_r);
        gl_r <= (I_SRST || O_OUTPUT_GATE_N) ? 5'h00 : inc(gl_r);
        ws_r <= I_SRST ? 5'h1f : ($fell(O_WRITE_STROBE_N) ? 5'h01 : inc(ws_r));
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    strobe_width_a: assert property ($rose(O_WRITE_STROBE_N) |-> wl_r >= 5'h09)
        else $error("write strobe pulse too short");
    select_lead_a: assert property ($rose(O_WRITE_STROBE_N) |-> sl_r >= 5'h09)
        else $error("selects not active long enough before write end");
    write_period_a: assert property ($fell(O_WRITE_STROBE_N) |-> ws_r >= 5'h0c)
        else $error("write cycles too close");
    addr_hold_a: assert property ((!$past(O_WRITE_STROBE_N) || !$past(O_OUTPUT_GATE_N))
        |-> $stable(O_ADDR))
        else $error("address moved during access");
    lane_hold_a: assert property (!$past(O_WRITE_STROBE_N) && !O_WRITE_STROBE_N
        |-> $stable({O_UPPER_LANE_SELECT_N, O_LOWER_LANE_SELECT_N}))
        else $error("lane selects moved during write");
    data_setup_a: assert property ($rose(O_WRITE_STROBE_N) |-> O_DQ_OE && oe_r >= 5'h07)
        else $error("write data setup too short");
    data_stable_a: assert property (O_DQ_OE && $past(O_DQ_OE) |-> $stable(O_DQ))
        else $error("write data moved while driven");
    release_wait_a: assert property ($rose(O_DQ_OE)
        |-> !O_WRITE_STROBE_N && !$past(O_WRITE_STROBE_N, 5))
        else $error("data driven before memory released");
    write_quals_a: assert property (!O_WRITE_STROBE_N |-> sel && O_OUTPUT_GATE_N)
        else $error("write without selects or with gate on");
    read_period_a: assert property ($rose(O_OUTPUT_GATE_N) |-> gl_r >= 5'h0c)
        else $error("read cycle too short");
endmodule // asc_ctrl_props

// ### test/asc_sram_model.sv
// behavioural model of the static ram on the controller's far side
`timescale 1ns/1ps

module asc_sram_model #(
    parameter int ACC_NS = 45 // read access time
) (
    input wire logic i_cs_n, // select, low active
    input wire logic i_cs, // select, high active
    input wire logic i_we_n, // write strobe
    input wire logic i_oe_n, // output gate
    input wire asc_pkg::asc_lane_t i_ln_n, // lanes, bit1 upper
    input wire asc_pkg::asc_addr_t i_a, // word address
    input wire asc_pkg::asc_data_t i_cd, // controller data
    input wire logic i_cd_oe, // controller drives
    output asc_pkg::asc_data_t o_bus // resolved data pins
);
    import asc_pkg::*;
    asc_data_t mem [asc_addr_t];
    asc_data_t rd_q = 16'h0000;
    asc_data_t rd_drv;
    asc_data_t flt = 16'h5a3c;
    logic on;
    assign on = !i_cs_n && i_cs && !(&i_ln_n);
    always #3 flt = ~flt;
    // old word kept until access time runs out
    always @(i_a or i_we_n)
        rd_q <= #(ACC_NS) (mem.exists(i_a) ? mem[i_a] : 16'h0000);
    always_comb begin
        for (int i = 0; i < 2; i++)
            rd_drv[i*8 +: 8] = (on && i_we_n && !i_oe_n && !i_ln_n[i]) ? rd_q[i*8 +: 8]
                : flt[i*8 +: 8];
    end
    assign o_bus = i_cd_oe ? i_cd : rd_drv;
    always @* begin
        if (on && !i_we_n)
            for (int i = 0; i < 2; i++)
                if (!i_ln_n[i]) mem[i_a][i*8 +: 8] = o_bus[i*8 +: 8];
    end
endmodule // asc_sram_model

// ### test/tb_async_sram_bus_cycles.sv
// self-checking bench for the static ram controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end

bind asc_ctrl asc_ctrl_props chk (.I_CLK(I_CLK), .I_SRST(I_SRST), .O_ADDR(O_ADDR),
    .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_SELECT_LOW_ACTIVE_N(O_SELECT_LOW_ACTIVE_N),
    .O_SELECT_HIGH_ACTIVE(O_SELECT_HIGH_ACTIVE), .O_WRITE_STROBE_N(O_WRITE_STROBE_N),
    .O_OUTPUT_GATE_N(O_OUTPUT_GATE_N), .O_UPPER_LANE_SELECT_N(O_UPPER_LANE_SELECT_N),
    .O_LOWER_LANE_SELECT_N(O_LOWER_LANE_SELECT_N));

module tb_async_sram_bus_cycles;
    import asc_pkg::*;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, req = 1'b0, wr = 1'b0;
    asc_addr_t addr = 20'h00000;
    asc_addr_t pa;
    asc_data_t wdata = 16'h0000;
    asc_data_t rdata, bus, pd, got;
    asc_lane_t lane_n = 2'b00;
    logic ready, rvalid, dq_oe, sl_n, sh, we_n, oe_n, up_n, lo_n;
    int miscompares = 0, compares = 0, cyc = 0, rv, rdy;
    always #2 clk = ~clk;
    asc_ctrl dut (.I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_REQ(req), .I_WRITE(wr),
        .I_ADDR(addr), .I_WDATA(wdata), .I_LANE_N(lane_n), .O_READY(ready),
        .O_RVALID(rvalid), .O_RDATA(rdata), .O_ADDR(pa), .O_SELECT_LOW_ACTIVE_N(sl_n),
        .O_SELECT_HIGH_ACTIVE(sh), .O_WRITE_STROBE_N(we_n), .O_OUTPUT_GATE_N(oe_n),
        .O_UPPER_LANE_SELECT_N(up_n), .O_LOWER_LANE_SELECT_N(lo_n), .I_DQ(bus),
        .O_DQ(pd), .O_DQ_OE(dq_oe));
    asc_sram_model sram (.i_cs_n(sl_n), .i_cs(sh), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_ln_n({up_n, lo_n}), .i_a(pa), .i_cd(pd), .i_cd_oe(dq_oe), .o_bus(bus));
    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            conclude();
        end
    end
    // one request; hold keeps req up while busy, gap freezes the clock enable
    task automatic xfer(input logic w, input asc_addr_t a, input asc_data_t d,
            input asc_lane_t l, input int hold, input int gap);
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        lane_n <= l;
        @(posedge clk);
        addr <= ~a;
        if (hold == 0) req <= 1'b0;
        rv = -1;
        for (rdy = 0; rdy < 40; rdy++) begin
            @(negedge clk);
            if (rvalid) begin
                rv = rdy;
                got = rdata;
            end
            if (ready) break;
            @(posedge clk);
            if (hold != 0 && rdy + 1 >= hold) req <= 1'b0;
            if (gap != 0 && rdy + 1 == 3) ce <= 1'b0;
            if (gap != 0 && rdy + 1 == 3 + gap) ce <= 1'b1;
        end
        `CHK("xfer done", 1'b1, ready)
    endtask
    task automatic t_idle;
        @(negedge clk);
        `CHK("ready", 1'b1, ready)
        `CHK("pins", 6'h2f, {sl_n, sh, we_n, oe_n, up_n, lo_n})
        `CHK("dq_oe", 1'b0, dq_oe)
    endtask
    task automatic t_word;
        xfer(1'b1, 20'hfffff, 16'hc3a5, 2'b00, 0, 0);
        `CHK("wr ready", 13, rdy)
        xfer(1'b0, 20'hfffff, 16'h0000, 2'b00, 0, 0);
        `CHK("rd valid", 12, rv)
        `CHK("rd ready", 17, rdy)
        `CHK("rd data", 16'hc3a5, got)
        `CHK("addr", 20'hfffff, pa)
    endtask
    task automatic t_lanes;
        asc_data_t exp, d, m;
        asc_lane_t ln;
        exp = 16'h1234;
        for (int c = 0; c < 4; c++) begin
            ln = c[1:0];
            d = exp ^ 16'h5aa5;
            xfer(1'b1, 20'h00000, d, ln, 0, 0);
            if (!ln[0]) exp[7:0] = d[7:0];
            if (!ln[1]) exp[15:8] = d[15:8];
            xfer(1'b0, 20'h00000, 16'h0000, 2'b00, 0, 0);
            `CHK("lane word", exp, got)
            xfer(1'b0, 20'h00000, 16'h0000, ln, 0, 0);
            m = {{8{!ln[1]}}, {8{!ln[0]}}};
            `CHK("lane read", exp & m, got & m)
        end
    endtask
    task automatic t_busy;
        xfer(1'b1, 20'h00abc, 16'hbeef, 2'b00, 12, 0);
        `CHK("busy ready", 13, rdy)
        `CHK("busy addr", 20'h00abc, pa)
        xfer(1'b0, 20'h00abc, 16'h0000, 2'b00, 0, 4);
        `CHK("frozen valid", 16, rv)
        `CHK("busy data", 16'hbeef, got)
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_idle();
        t_word();
        t_lanes();
        t_busy();
        conclude();
    end
endmodule // tb_async_sram_bus_cycles
